/* core/dofs_pkg.sv */
// Constants and mode codes for the digital output function select block
// What this block does
// - Readback: first output left, second right
// - Single-output variant reads back first output only
// - Per-output mode code 0..21, resets to 0
// - Codes 1,2: mains ready, software limit
// - Codes 3-6: move done, position, above, below
// - Codes 7,8,10,11 status; code 9 reserved
// - Codes 12-14: velocity above, below, homing done
// - Code 15: OR of limit switch flags
// - Codes 16,17: command buffer, task in position
// - Codes 19-21: index, controlled stop, power fault
// - Signed threshold, range follows current mode
// - Modes 4-6 accept position min..max
// - Modes 12,13 accept zero..velocity max
// - Other modes accept threshold zero only
// - Cyclic network disables status-driven functions
// - Changed mode write clears threshold
// - Mode 0 drives user output level
// - Source bit: 0 internal, 1 fieldbus
package dofs_pkg;

    localparam logic [7:0]  OFF_READBACK = 8'hc2;
    localparam logic [7:0]  OFF_MODE1    = 8'hc4;
    localparam logic [7:0]  OFF_THR1     = 8'hc6;
    localparam logic [7:0]  OFF_MODE2    = 8'hce;
    localparam logic [7:0]  OFF_THR2     = 8'hd0;

    localparam logic [7:0]  MODE_MAX     = 8'h15;
    localparam logic [7:0]  RST_MODE     = 8'h00;
    localparam logic [63:0] RST_THR      = 64'h0000_0000_0000_0000;
    localparam logic [1:0]  RST_LEVELS   = 2'h0;

    localparam int          PLS_W        = 8;

    typedef enum logic [7:0] {
        MODE_USER        = 8'h00,
        MODE_MAINS_READY = 8'h01,
        MODE_SW_LIMIT    = 8'h02,
        MODE_MOVE_DONE   = 8'h03,
        MODE_IN_POS      = 8'h04,
        MODE_POS_ABOVE   = 8'h05,
        MODE_POS_BELOW   = 8'h06,
        MODE_WARNING     = 8'h07,
        MODE_ENABLED     = 8'h08,
        MODE_RESERVED    = 8'h09,
        MODE_BRAKE       = 8'h0a,
        MODE_FAULT       = 8'h0b,
        MODE_VEL_ABOVE   = 8'h0c,
        MODE_VEL_BELOW   = 8'h0d,
        MODE_HOMED       = 8'h0e,
        MODE_PLS_ANY     = 8'h0f,
        MODE_CMD_BUF     = 8'h10,
        MODE_TASK_IN_POS = 8'h11,
        MODE_UNASSIGNED  = 8'h12,
        MODE_INDEX       = 8'h13,
        MODE_CTRL_STOP   = 8'h14,
        MODE_PWR_FAULT   = 8'h15
    } dofs_mode_t;

endpackage

/* core/dofs_chan.sv */
// One output's function select and threshold storage
`timescale 1ns/100ps
module dofs_chan (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               mode_we,
    input  wire logic               thr_we,
    input  wire logic [63:0]        wdata,
    output logic [7:0]              mode_ff,
    output logic signed [63:0]      thr_ff
);

    logic [7:0]         nxt_mode;
    logic signed [63:0] nxt_thr;

    always_comb begin
        nxt_mode = mode_ff;
        nxt_thr  = thr_ff;
        if (mode_we) begin
            nxt_mode = wdata[7:0];
            // Old threshold may be meaningless under the new mode
            if (wdata[7:0] != mode_ff) begin
                nxt_thr = dofs_pkg::RST_THR;
            end
        end else if (thr_we) begin
            nxt_thr = wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= dofs_pkg::RST_MODE;
            thr_ff  <= dofs_pkg::RST_THR;
        end else begin
            mode_ff <= nxt_mode;
            thr_ff  <= nxt_thr;
        end
    end

endmodule // dofs_chan

/* core/dofs_top.sv */
// Digital output function select: registers, source mux, output flops
`timescale 1ns/100ps
module dofs_top #(
    parameter bit SINGLE_OUTPUT = 1'b0
) (
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    input  wire logic                        reg_wr_en,
    input  wire logic                        reg_rd_en,
    input  wire logic [7:0]                  reg_addr,
    input  wire logic [63:0]                 reg_wdata,
    output logic [63:0]                      reg_rdata,
    output logic                             reg_ack,
    output logic                             reg_err,
    input  wire logic                        fieldbus_ctrl,
    input  wire logic                        fieldbus_first_level,
    input  wire logic                        fieldbus_second_level,
    input  wire logic                        user_output_level_first,
    input  wire logic                        user_output_level_second,
    input  wire logic                        network_cyclic,
    input  wire logic                        mains_ready,
    input  wire logic                        sw_limit_reached,
    input  wire logic                        move_done,
    input  wire logic                        in_position,
    input  wire logic                        warning_present,
    input  wire logic                        drive_enabled,
    input  wire logic                        motor_brake,
    input  wire logic                        fault_present,
    input  wire logic                        homing_done,
    input  wire logic [dofs_pkg::PLS_W-1:0]  position_limit_switch_flags,
    input  wire logic                        cmd_buffer_active,
    input  wire logic                        task_in_position,
    input  wire logic                        encoder_index,
    input  wire logic                        ctrl_stop_active,
    input  wire logic                        fault_power_stage,
    input  wire logic signed [63:0]          position,
    input  wire logic signed [63:0]          velocity,
    input  wire logic signed [63:0]          position_min,
    input  wire logic signed [63:0]          position_max,
    input  wire logic signed [63:0]          velocity_max,
    output logic                             first_output,
    output logic                             second_output
);

    logic [7:0]         mode_w [2];
    logic signed [63:0] thr_w  [2];
    logic [1:0]         mode_we;
    logic [1:0]         thr_we;
    logic [1:0]         thr_ok;
    logic [1:0]         user_lvl;
    logic [1:0]         fb_lvl;
    logic [1:0]         lvl;
    logic [1:0]         dout_ff;
    logic [1:0]         nxt_dout;
    logic [63:0]        reg_rdata_ff;
    logic [63:0]        nxt_rdata;
    logic               reg_ack_ff;
    logic               nxt_ack;
    logic               reg_err_ff;
    logic               nxt_err;
    logic signed [63:0] abs_vel;
    logic               pls_any;

    assign user_lvl = {user_output_level_second, user_output_level_first};
    assign fb_lvl   = {fieldbus_second_level, fieldbus_first_level};
    assign abs_vel  = (velocity < 0) ? -velocity : velocity;
    assign pls_any  = |position_limit_switch_flags;

    // Legal threshold window for a mode, also used by both channels
    function automatic logic thr_in_range(
        input logic [7:0]         mode,
        input logic signed [63:0] v,
        input logic signed [63:0] pmin,
        input logic signed [63:0] pmax,
        input logic signed [63:0] vmax
    );
        logic ok;
        case (mode)
            dofs_pkg::MODE_IN_POS,
            dofs_pkg::MODE_POS_ABOVE,
            dofs_pkg::MODE_POS_BELOW: begin
                ok = (v >= pmin) && (v <= pmax);
            end
            dofs_pkg::MODE_VEL_ABOVE,
            dofs_pkg::MODE_VEL_BELOW: begin
                ok = (v >= 0) && (v <= vmax);
            end
            default: begin
                ok = (v == 0);
            end
        endcase
        return ok;
    endfunction

    // Readback word: first output in the higher bit, or in bit 0 in the single-output build
    function automatic logic [63:0] readback(input logic [1:0] d);
        logic [63:0] r;
        r = '0;
        if (SINGLE_OUTPUT) begin
            r[0] = d[0];
        end else begin
            r[1] = d[0];
            r[0] = d[1];
        end
        return r;
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            dofs_chan u_chan (
                .clk     (clk),
                .rst_n   (rst_n),
                .mode_we (mode_we[gi]),
                .thr_we  (thr_we[gi]),
                .wdata   (reg_wdata),
                .mode_ff (mode_w[gi]),
                .thr_ff  (thr_w[gi])
            );

            always_comb begin
                thr_ok[gi] = thr_in_range(mode_w[gi], reg_wdata,
                                          position_min, position_max,
                                          velocity_max);
            end

            always_comb begin
                case (mode_w[gi])
                    dofs_pkg::MODE_USER:        lvl[gi] = user_lvl[gi];
                    dofs_pkg::MODE_MAINS_READY: lvl[gi] = mains_ready;
                    dofs_pkg::MODE_SW_LIMIT:    lvl[gi] = sw_limit_reached;
                    dofs_pkg::MODE_MOVE_DONE:   lvl[gi] = move_done;
                    dofs_pkg::MODE_IN_POS:      lvl[gi] = in_position;
                    dofs_pkg::MODE_POS_ABOVE:   lvl[gi] = position > thr_w[gi];
                    dofs_pkg::MODE_POS_BELOW:   lvl[gi] = position < thr_w[gi];
                    dofs_pkg::MODE_WARNING:     lvl[gi] = warning_present;
                    dofs_pkg::MODE_ENABLED:     lvl[gi] = drive_enabled;
                    dofs_pkg::MODE_BRAKE:       lvl[gi] = motor_brake;
                    dofs_pkg::MODE_FAULT:       lvl[gi] = fault_present;
                    dofs_pkg::MODE_VEL_ABOVE:   lvl[gi] = abs_vel > thr_w[gi];
                    dofs_pkg::MODE_VEL_BELOW:   lvl[gi] = abs_vel < thr_w[gi];
                    dofs_pkg::MODE_HOMED:       lvl[gi] = homing_done;
                    dofs_pkg::MODE_PLS_ANY:     lvl[gi] = pls_any;
                    dofs_pkg::MODE_CMD_BUF:     lvl[gi] = cmd_buffer_active;
                    dofs_pkg::MODE_TASK_IN_POS: lvl[gi] = task_in_position;
                    dofs_pkg::MODE_INDEX:       lvl[gi] = encoder_index;
                    dofs_pkg::MODE_CTRL_STOP:   lvl[gi] = ctrl_stop_active;
                    dofs_pkg::MODE_PWR_FAULT:   lvl[gi] = fault_power_stage;
                    default:                    lvl[gi] = 1'b0;
                endcase
            end

            always_comb begin
                if (fieldbus_ctrl) begin
                    nxt_dout[gi] = fb_lvl[gi];
                end else if (network_cyclic &&
                             (mode_w[gi] != dofs_pkg::MODE_USER)) begin
                    // User mode stays live so software keeps a way out
                    nxt_dout[gi] = 1'b0;
                end else begin
                    nxt_dout[gi] = lvl[gi];
                end
            end
        end
    endgenerate

    // Register port; a write takes priority over a read in the same cycle
    always_comb begin
        mode_we   = '0;
        thr_we    = '0;
        nxt_rdata = reg_rdata_ff;
        nxt_ack   = 1'b0;
        nxt_err   = 1'b0;
        if (reg_wr_en) begin
            nxt_ack = 1'b1;
            case (reg_addr)
                dofs_pkg::OFF_MODE1: begin
                    if (reg_wdata <= {56'h0, dofs_pkg::MODE_MAX}) begin
                        mode_we[0] = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
                dofs_pkg::OFF_MODE2: begin
                    if (reg_wdata <= {56'h0, dofs_pkg::MODE_MAX}) begin
                        mode_we[1] = 1'b1;
                    end else begin
                        nxt_err = 1'b1;
                    end
                end
                dofs_pkg::OFF_THR1: begin
                    thr_we[0] = thr_ok[0];
                    nxt_err   = !thr_ok[0];
                end
                dofs_pkg::OFF_THR2: begin
                    thr_we[1] = thr_ok[1];
                    nxt_err   = !thr_ok[1];
                end
                default: begin
                    nxt_err = 1'b1;
                end
            endcase
        end else if (reg_rd_en) begin
            nxt_ack = 1'b1;
            case (reg_addr)
                dofs_pkg::OFF_READBACK: nxt_rdata = readback(dout_ff);
                dofs_pkg::OFF_MODE1:    nxt_rdata = {56'h0, mode_w[0]};
                dofs_pkg::OFF_THR1:     nxt_rdata = thr_w[0];
                dofs_pkg::OFF_MODE2:    nxt_rdata = {56'h0, mode_w[1]};
                dofs_pkg::OFF_THR2:     nxt_rdata = thr_w[1];
                default: begin
                    nxt_rdata = '0;
                    nxt_err   = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_ff      <= dofs_pkg::RST_LEVELS;
            reg_rdata_ff <= dofs_pkg::RST_THR;
            reg_ack_ff   <= 1'b0;
            reg_err_ff   <= 1'b0;
        end else begin
            dout_ff      <= nxt_dout;
            reg_rdata_ff <= nxt_rdata;
            reg_ack_ff   <= nxt_ack;
            reg_err_ff   <= nxt_err;
        end
    end

    assign first_output  = dout_ff[0];
    assign second_output = dout_ff[1];
    assign reg_rdata     = reg_rdata_ff;
    assign reg_ack       = reg_ack_ff;
    assign reg_err       = reg_err_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_READBACK: assert property (
        (reg_rd_en && !reg_wr_en && reg_addr == dofs_pkg::OFF_READBACK)
        |=> (reg_rdata == readback($past(dout_ff))) && reg_ack)
        else $error("Readback word does not match output levels");

    AST_MODE_RANGE: assert property (
        (mode_w[0] <= dofs_pkg::MODE_MAX) && (mode_w[1] <= dofs_pkg::MODE_MAX))
        else $error("Mode code outside 0 to 21");

    AST_USER_LEVEL: assert property (
        (!fieldbus_ctrl && mode_w[0] == dofs_pkg::MODE_USER)
        |=> first_output == $past(user_output_level_first))
        else $error("User mode does not follow user level");

    AST_FIELDBUS: assert property (
        fieldbus_ctrl |=> ({second_output, first_output} == $past(fb_lvl)))
        else $error("Fieldbus source not driving outputs");

    AST_RESERVED: assert property (
        (!fieldbus_ctrl && (mode_w[1] == dofs_pkg::MODE_RESERVED ||
                            mode_w[1] == dofs_pkg::MODE_UNASSIGNED))
        |=> !second_output)
        else $error("Unassigned mode drove output active");

    AST_CYCLIC: assert property (
        (!fieldbus_ctrl && network_cyclic &&
         mode_w[0] != dofs_pkg::MODE_USER) |=> !first_output)
        else $error("Status function live during cyclic operation");

    AST_CLEAR: assert property (
        (mode_we[0] && reg_wdata[7:0] != mode_w[0]) |=> (thr_w[0] == 0))
        else $error("Threshold not cleared on mode change");

    AST_REFUSE: assert property (
        (reg_wr_en && reg_addr == dofs_pkg::OFF_THR2 && !thr_ok[1])
        |=> (thr_w[1] == $past(thr_w[1])) && reg_err)
        else $error("Out-of-range threshold was stored");

    AST_ZERO_ONLY: assert property (
        !(mode_w[0] inside {dofs_pkg::MODE_IN_POS, dofs_pkg::MODE_POS_ABOVE,
          dofs_pkg::MODE_POS_BELOW, dofs_pkg::MODE_VEL_ABOVE,
          dofs_pkg::MODE_VEL_BELOW}) |-> (thr_w[0] == 0))
        else $error("Nonzero threshold in a mode without one");

    AST_POS_ABOVE: assert property (
        (!fieldbus_ctrl && !network_cyclic &&
         mode_w[0] == dofs_pkg::MODE_POS_ABOVE)
        |=> first_output == ($past(position) > $past(thr_w[0])))
        else $error("Position above threshold output wrong");

    AST_VEL_ACCEPT: assert property (
        (reg_wr_en && reg_addr == dofs_pkg::OFF_THR1 &&
         mode_w[0] == dofs_pkg::MODE_VEL_ABOVE && $signed(reg_wdata) >= 0 &&
         $signed(reg_wdata) <= velocity_max)
        |=> (thr_w[0] == $past(reg_wdata)) && !reg_err)
        else $error("Legal velocity threshold refused");

    COV_MODE_CHANGE: cover property (mode_we[0] && reg_wdata[7:0] != mode_w[0]);
    COV_THR_REFUSED: cover property (reg_wr_en && reg_addr ==
                                     dofs_pkg::OFF_THR1 && !thr_ok[0]);
    COV_POS_ACTIVE:  cover property (mode_w[1] == dofs_pkg::MODE_POS_BELOW
                                     && second_output);
    COV_CYCLIC:      cover property (network_cyclic && !fieldbus_ctrl
                                     && mode_w[0] == dofs_pkg::MODE_FAULT);

endmodule // dofs_top

/* dv/dofs_load.sv */
// Load model for the two driven output pins
`timescale 1ns/100ps
module dofs_load (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic first_output,
    input  wire logic second_output,
    output logic      first_on_ff,
    output logic      second_on_ff
);
    logic nxt_first_on;
    logic nxt_second_on;

    // Resistive loads follow the pin; one flop stands in for the wiring delay
    always_comb begin
        nxt_first_on  = first_output;
        nxt_second_on = second_output;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_on_ff  <= 1'b0;
            second_on_ff <= 1'b0;
        end else begin
            first_on_ff  <= nxt_first_on;
            second_on_ff <= nxt_second_on;
        end
    end
endmodule // dofs_load

/* dv/dofs_top_tb.sv */
// Self-checking bench for the output function select block
`timescale 1ns/100ps
module dofs_top_tb;
    localparam longint PMIN = -1000;
    localparam longint PMAX = 1000;
    localparam longint VMAX = 500;
    logic               clk;
    logic               rst_n;
    logic               reg_wr_en;
    logic               reg_rd_en;
    logic [7:0]         reg_addr;
    logic [63:0]        reg_wdata;
    logic [63:0]        reg_rdata;
    logic               reg_ack;
    logic               reg_err;
    logic               fb_ctrl;
    logic [1:0]         fb_lvl;
    logic [1:0]         usr_lvl;
    logic               cyclic;
    logic [13:0]        st;
    logic [7:0]         pls;
    logic signed [63:0] pos;
    logic signed [63:0] vel;
    logic [1:0]         outs;
    logic [1:0]         loads;
    logic [63:0]        rdata_one;
    int                 n_errors;
    int                 n_compared;
    int                 cycles;
    int                 seed_ret;
    int                 mmode [2];
    longint             mthr [2];
    // Status bit feeding each plain condition code
    int smap [22] = '{-1, 0, 1, 2, 3, -1, -1, 4, 5, -1, 6, 7, -1, -1, 8, -1,
                      9, 10, -1, 11, 12, 13};
    longint bnd [8] = '{PMIN - 1, PMIN, PMAX, PMAX + 1, -1, 0, VMAX, VMAX + 1};

    dofs_top #(.SINGLE_OUTPUT(1'b0)) u_dofs_top (
        .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .fieldbus_ctrl(fb_ctrl), .fieldbus_first_level(fb_lvl[0]),
        .fieldbus_second_level(fb_lvl[1]),
        .user_output_level_first(usr_lvl[0]),
        .user_output_level_second(usr_lvl[1]), .network_cyclic(cyclic),
        .mains_ready(st[0]), .sw_limit_reached(st[1]), .move_done(st[2]),
        .in_position(st[3]), .warning_present(st[4]), .drive_enabled(st[5]),
        .motor_brake(st[6]), .fault_present(st[7]), .homing_done(st[8]),
        .position_limit_switch_flags(pls), .cmd_buffer_active(st[9]),
        .task_in_position(st[10]), .encoder_index(st[11]),
        .ctrl_stop_active(st[12]), .fault_power_stage(st[13]),
        .position(pos), .velocity(vel), .position_min(PMIN),
        .position_max(PMAX), .velocity_max(VMAX),
        .first_output(outs[1]), .second_output(outs[0])
    );

    // Single-output build on the same stimulus; only its readback is compared
    if (1) begin : g_one
        dofs_top #(.SINGLE_OUTPUT(1'b1)) u_dofs_top (
            .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
            .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
            .reg_rdata(rdata_one), .reg_ack(), .reg_err(),
            .fieldbus_ctrl(fb_ctrl), .fieldbus_first_level(fb_lvl[0]),
            .fieldbus_second_level(fb_lvl[1]),
            .user_output_level_first(usr_lvl[0]),
            .user_output_level_second(usr_lvl[1]), .network_cyclic(cyclic),
            .mains_ready(st[0]), .sw_limit_reached(st[1]), .move_done(st[2]),
            .in_position(st[3]), .warning_present(st[4]),
            .drive_enabled(st[5]), .motor_brake(st[6]),
            .fault_present(st[7]), .homing_done(st[8]),
            .position_limit_switch_flags(pls), .cmd_buffer_active(st[9]),
            .task_in_position(st[10]), .encoder_index(st[11]),
            .ctrl_stop_active(st[12]), .fault_power_stage(st[13]),
            .position(pos), .velocity(vel), .position_min(PMIN),
            .position_max(PMAX), .velocity_max(VMAX),
            .first_output(), .second_output()
        );
    end

    dofs_load u_dofs_load (
        .clk(clk), .rst_n(rst_n), .first_output(outs[1]),
        .second_output(outs[0]), .first_on_ff(loads[1]),
        .second_on_ff(loads[0])
    );

    always #2.5 clk = ~clk;

    task automatic end_of_test();
        if (n_errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Ceiling is about seventeen times the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic bit thr_ok(input int m, input longint v);
        if (m >= 4 && m <= 6) return v >= PMIN && v <= PMAX;
        if (m == 12 || m == 13) return v >= 0 && v <= VMAX;
        return v == 0;
    endfunction

    function automatic logic exp_out(input int c);
        longint a;
        a = (vel < 0) ? -vel : vel;
        if (fb_ctrl) return fb_lvl[c];
        if (mmode[c] == 0) return usr_lvl[c];
        if (cyclic) return 1'b0;
        case (mmode[c])
            5: return pos > mthr[c];
            6: return pos < mthr[c];
            12: return a > mthr[c];
            13: return a < mthr[c];
            15: return |pls;
            9, 18: return 1'b0;
            default: return st[smap[mmode[c]]];
        endcase
    endfunction

    // One-cycle request pulse; answer sampled one edge after the take
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [63:0] d, output logic [63:0] q,
                       output logic e);
        @(posedge clk);
        reg_wr_en <= wr;
        reg_rd_en <= ~wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr_en <= 1'b0;
        reg_rd_en <= 1'b0;
        @(posedge clk);
        check(reg_ack, 1'b1);
        q = reg_rdata;
        e = reg_err;
    endtask

    task automatic wr(input logic [7:0] a, input longint v);
        logic [63:0] q;
        logic        e;
        logic        bad;
        int          c;
        c = (a == dofs_pkg::OFF_MODE2 || a == dofs_pkg::OFF_THR2);
        bad = 1'b1;
        if (a == dofs_pkg::OFF_MODE1 || a == dofs_pkg::OFF_MODE2) begin
            bad = v < 0 || v > 21;
            if (!bad && v != mmode[c]) mthr[c] = 0;
            if (!bad) mmode[c] = int'(v);
        end else if (a == dofs_pkg::OFF_THR1 || a == dofs_pkg::OFF_THR2) begin
            bad = !thr_ok(mmode[c], v);
            if (!bad) mthr[c] = v;
        end
        bus(1'b1, a, 64'(v), q, e);
        check(e, bad);
    endtask

    task automatic rd(input logic [7:0] a);
        logic [63:0] q;
        logic [63:0] exp;
        logic        e;
        logic        ok;
        int          c;
        c = (a == dofs_pkg::OFF_MODE2 || a == dofs_pkg::OFF_THR2);
        exp = 64'h0000_0000_0000_0000;
        ok = 1'b1;
        if (a == dofs_pkg::OFF_READBACK) exp = 64'({exp_out(0), exp_out(1)});
        else if (a == dofs_pkg::OFF_MODE1 || a == dofs_pkg::OFF_MODE2)
            exp = 64'(mmode[c]);
        else if (a == dofs_pkg::OFF_THR1 || a == dofs_pkg::OFF_THR2)
            exp = 64'(mthr[c]);
        else ok = 1'b0;
        bus(1'b0, a, 64'h0000_0000_0000_0000, q, e);
        check(q, exp);
        if (a == dofs_pkg::OFF_READBACK)
            check(rdata_one, 64'(exp_out(0)));
        check(e, !ok);
    endtask

    task automatic shake();
        @(posedge clk);
        st      <= 14'($urandom);
        pls     <= ($urandom_range(1) == 1) ? 8'($urandom) : 8'h00;
        usr_lvl <= 2'($urandom);
        fb_lvl  <= 2'($urandom);
        pos     <= 64'($urandom_range(2400)) - 64'sd1200;
        vel     <= 64'($urandom_range(1200)) - 64'sd600;
        // Output flop plus load flop: both settled after two edges, checked on the third
        repeat (3) @(posedge clk);
        check(outs, {exp_out(0), exp_out(1)});
        check(loads, {exp_out(0), exp_out(1)});
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 64'h0000_0000_0000_0000;
        {fb_ctrl, fb_lvl, usr_lvl, cyclic, st, pls} = '0;
        pos = 64'sd0;
        vel = 64'sd0;
        mmode = '{0, 0};
        mthr = '{0, 0};
        seed_ret = $urandom(32'hbebc_5f32);
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(dofs_pkg::OFF_MODE1);
        rd(dofs_pkg::OFF_MODE2);
        rd(dofs_pkg::OFF_THR1);
        rd(dofs_pkg::OFF_THR2);
        rd(dofs_pkg::OFF_READBACK);
        for (int m = 0; m <= 21; m++) begin
            wr(dofs_pkg::OFF_MODE1, m);
            wr(dofs_pkg::OFF_MODE2, 21 - m);
            wr(dofs_pkg::OFF_THR1, 300);
            wr(dofs_pkg::OFF_THR2, -300);
            rd(dofs_pkg::OFF_THR1);
            rd(dofs_pkg::OFF_THR2);
            repeat (6) shake();
            rd(dofs_pkg::OFF_READBACK);
        end
        // Range edges; rewriting the same mode must keep the threshold
        wr(dofs_pkg::OFF_MODE1, 5);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) wr(dofs_pkg::OFF_MODE1, 5);
            if (i == 4) rd(dofs_pkg::OFF_THR1);
            if (i == 4) wr(dofs_pkg::OFF_MODE1, 12);
            wr(dofs_pkg::OFF_THR1, bnd[i]);
            rd(dofs_pkg::OFF_THR1);
        end
        wr(dofs_pkg::OFF_MODE1, 22);
        wr(dofs_pkg::OFF_READBACK, 1);
        wr(8'h10, 1);
        rd(8'h10);
        rd(dofs_pkg::OFF_MODE1);
        wr(dofs_pkg::OFF_MODE1, 0);
        wr(dofs_pkg::OFF_MODE2, 1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cyclic  <= i[0];
            fb_ctrl <= i[1];
            repeat (4) shake();
            rd(dofs_pkg::OFF_READBACK);
        end
        end_of_test();
    end
endmodule // dofs_top_tb
